// >>> shared/mce_consts.vh
// Constants for the instruction-subset execution core.
// Assumes inclusion by bare name from the core files; definitions only.
`ifndef MCE_CONSTS_VH
`define MCE_CONSTS_VH
// Opcode field position in the 16-bit instruction word
`define MCE_OP_MSB 15
`define MCE_OP_LSB 12
// Operand field (data address or immediate) position
`define MCE_ARG_MSB 7
`define MCE_ARG_LSB 0
// Jump address field position
`define MCE_JADDR_MSB 11
`define MCE_JADDR_LSB 0
// Opcode encodings (4 bits)
`define MCE_OP_NO_OP 4'h0
`define MCE_OP_DECA 4'h1
`define MCE_OP_HALT 4'h2
`define MCE_OP_INC 4'h3
`define MCE_OP_INC_ACC 4'h4
`define MCE_OP_JUMP 4'h5
`define MCE_OP_LOAD_MEM 4'h6
`define MCE_OP_LOAD_IMM 4'h7
`define MCE_OP_STORE 4'h8
// Reset values
`define MCE_RST_PC 12'h000
`define MCE_RST_ACC 8'h00
`define MCE_RST_DOG 8'h00
`define MCE_RST_PRE 8'h00
`endif

// >>> core/mce_wdt_count.v
// Watchdog timer with prescaler, cleared by the core on power-down entry.
// Assumes one system clock; counting stops when the clock is gated.
module mce_watchdog_count #(
  parameter PRE_W = 8,
  parameter WDT_W = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire clr,
  output reg [PRE_W-1:0] pre_q,
  output reg [WDT_W-1:0] dog_q
);
  ////////////////////////////////////////////////////////////////
  // Prescaler feeds a one-cycle enable into the watchdog count
  always @(posedge clk) begin
    if (sys_rst || clr) begin
      pre_q <= {PRE_W{1'b0}};
      dog_q <= {WDT_W{1'b0}};
    end else begin
      pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
      if (&pre_q) begin
        dog_q <= dog_q + {{(WDT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// >>> core/mce_exec.v
// Execution core for a subset of an 8-bit microcontroller instruction set.
// Assumes program memory answers combinationally on prog_data for prog_addr,
// and data memory reads combinationally with a synchronous write strobe.
// The clock keeps toggling at the pin while powered down; the core gates itself
// through its state, and sys_clk_en tells the surroundings to stop the clock.
`include "mce_consts.vh"
module mce_exec #(
  parameter PC_W = 12,
  parameter DADDR_W = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire wake,
  output wire [PC_W-1:0] prog_addr,
  input wire [15:0] prog_data,
  output wire [DADDR_W-1:0] data_addr,
  input wire [7:0] data_rdata,
  output reg [7:0] data_wdata,
  output reg data_we,
  output wire [7:0] acc,
  output wire zero_flag,
  output wire power_down_flag,
  output wire watchdog_timeout_flag,
  input wire watchdog_timeout_set,
  output wire sys_clk_en,
  output wire [7:0] watchdog_count,
  output wire [7:0] watchdog_prescale
);
  ////////////////////////////////////////////////////////////////
  // State codes, one-hot
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_DUMMY = 3'b010;
  localparam [2:0] ST_HALT = 3'b100;

  localparam [PC_W-1:0] PC_ONE = {{(PC_W-1){1'b0}}, 1'b1};

  // Architectural state and its next values
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [PC_W-1:0] pc_q;
  reg [PC_W-1:0] pc_d;
  reg [7:0] acc_q;
  reg [7:0] acc_d;
  reg z_q;
  reg z_d;
  reg pd_flag_q;
  reg pd_flag_d;
  reg tmo_flag_q;
  reg tmo_flag_d;
  reg dog_clr;

  ////////////////////////////////////////////////////////////////
  // Instruction fields and arithmetic on the addressed byte
  wire [3:0] op = prog_data[`MCE_OP_MSB:`MCE_OP_LSB];
  wire [7:0] arg = prog_data[`MCE_ARG_MSB:`MCE_ARG_LSB];
  wire [PC_W-1:0] jaddr = prog_data[PC_W-1:0];
  wire [7:0] mem_inc = data_rdata + 8'h01;
  wire [7:0] mem_dec = data_rdata - 8'h01;

  // Opcode decode, qualified by the run state so dummy and halted cycles do nothing
  wire running = st_q[0];
  wire dec_dec_acc = running && (op == `MCE_OP_DECA);
  wire dec_halt = running && (op == `MCE_OP_HALT);
  wire dec_inc_mem = running && (op == `MCE_OP_INC);
  wire dec_inc_acc = running && (op == `MCE_OP_INC_ACC);
  wire dec_jump = running && (op == `MCE_OP_JUMP);
  wire dec_load_mem = running && (op == `MCE_OP_LOAD_MEM);
  wire dec_load_imm = running && (op == `MCE_OP_LOAD_IMM);
  wire dec_store = running && (op == `MCE_OP_STORE);

  // Outputs straight from the registers, except data_addr, taken from the instruction's operand field, and sys_clk_en, the inverted halt state bit
  assign prog_addr = pc_q;
  assign data_addr = arg[DADDR_W-1:0];
  assign acc = acc_q;
  assign zero_flag = z_q;
  assign power_down_flag = pd_flag_q;
  assign watchdog_timeout_flag = tmo_flag_q;
  assign sys_clk_en = ~st_q[2];

  ////////////////////////////////////////////////////////////////
  // Watchdog and prescaler
  mce_watchdog_count #(
    .PRE_W(8),
    .WDT_W(8)
  ) u_dog (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(dog_clr),
    .pre_q(watchdog_prescale),
    .dog_q(watchdog_count)
  );

  ////////////////////////////////////////////////////////////////
  // Sequencing: program counter, run/dummy/halt state, watchdog clear.
  // The count is held cleared for as long as the core is powered down,
  // since the system clock that would advance it is meant to be off.
  always @* begin
    st_d = st_q;
    pc_d = pc_q;
    dog_clr = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (dec_jump) begin
          pc_d = jaddr;
          st_d = ST_DUMMY;
        end else if (dec_halt) begin
          st_d = ST_HALT;
          dog_clr = 1'b1;
        end else begin
          pc_d = pc_q + PC_ONE;
        end
      end
      ST_DUMMY: begin
        st_d = ST_RUN;
      end
      ST_HALT: begin
        dog_clr = ~wake;
        if (wake) begin
          st_d = ST_RUN;
          pc_d = pc_q + PC_ONE;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Accumulator and zero flag; moves leave the flag alone
  always @* begin
    acc_d = acc_q;
    z_d = z_q;
    if (dec_dec_acc) begin
      acc_d = mem_dec;
      z_d = (mem_dec == 8'h00);
    end
    if (dec_inc_mem) begin
      z_d = (mem_inc == 8'h00);
    end
    if (dec_inc_acc) begin
      acc_d = mem_inc;
      z_d = (mem_inc == 8'h00);
    end
    if (dec_load_mem) begin
      acc_d = data_rdata;
    end
    if (dec_load_imm) begin
      acc_d = arg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Status flags; power-down entry beats a time-out in the same cycle
  always @* begin
    pd_flag_d = pd_flag_q;
    tmo_flag_d = tmo_flag_q | watchdog_timeout_set;
    if (dec_halt) begin
      pd_flag_d = 1'b1;
      tmo_flag_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Data memory write strobe, one cycle per writing instruction
  always @* begin
    data_we = 1'b0;
    data_wdata = acc_q;
    if (dec_inc_mem) begin
      data_we = 1'b1;
      data_wdata = mem_inc;
    end
    if (dec_store) begin
      data_we = 1'b1;
      data_wdata = acc_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Architectural registers
  always @(posedge clk) begin
    if (sys_rst) begin
      st_q <= ST_RUN;
      pc_q <= `MCE_RST_PC;
      acc_q <= `MCE_RST_ACC;
      z_q <= 1'b0;
      pd_flag_q <= 1'b0;
      tmo_flag_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      z_q <= z_d;
      pd_flag_q <= pd_flag_d;
      tmo_flag_q <= tmo_flag_d;
    end
  end
endmodule

// >>> tb/mce_exec_props.sv
// Port checker for the execution core.
// Assumes one clock and a synchronous active-high reset.
module mce_exec_props #(parameter PC_W = 12, parameter DADDR_W = 8) (
  input wire clk,
  input wire sys_rst,
  input wire wake,
  input wire [PC_W-1:0] prog_addr,
  input wire [15:0] prog_data,
  input wire [7:0] data_rdata,
  input wire [7:0] data_wdata,
  input wire data_we,
  input wire [7:0] acc,
  input wire zero_flag,
  input wire power_down_flag,
  input wire watchdog_timeout_flag,
  input wire sys_clk_en
);
  reg dmy_q;
  wire ex = sys_clk_en && !dmy_q;
  wire [3:0] op = prog_data[15:12];
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Marks the dummy cycle after a jump
  always @(posedge clk) dmy_q <= !sys_rst && ex && op == 4'h5;
  ////////////////////////////////////////
  a_dec_to_acc: assert property (ex && op == 4'h1 |->
    !data_we ##1 acc == $past(data_rdata) - 8'h01 && zero_flag == (acc == 8'h00)) else $error("dec wrong");
  a_halt_entry: assert property (ex && op == 4'h2 |=>
    !sys_clk_en && power_down_flag && !watchdog_timeout_flag) else $error("halt entry wrong");
  a_halt_keeps: assert property (!sys_clk_en && !wake |->
    !data_we ##1 $stable(acc) && $stable(prog_addr) && $stable(zero_flag)) else $error("halt not held");
  a_inc_mem: assert property (ex && op == 4'h3 |->
    data_we && data_wdata == data_rdata + 8'h01 ##1 zero_flag == ($past(data_wdata) == 8'h00)) else $error("inc wrong");
  a_inc_to_acc: assert property (ex && op == 4'h4 |->
    !data_we ##1 acc == $past(data_rdata) + 8'h01 && zero_flag == (acc == 8'h00)) else $error("acc increment wrong");
  a_jump_two: assert property (ex && op == 4'h5 |=> prog_addr == $past(prog_data[11:0]) &&
    $stable(zero_flag) && !data_we ##1 $stable(prog_addr) && $stable(acc)) else $error("jump wrong");
  a_move_load: assert property (ex && op[3:1] == 3'h3 |=> $stable(zero_flag) &&
    acc == ($past(op[0]) ? $past(prog_data[7:0]) : $past(data_rdata))) else $error("move wrong");
  a_idle_step: assert property (ex && op == 4'h0 |-> !data_we ##1
    prog_addr == $past(prog_addr) + 1'b1 && $stable(acc) && $stable(zero_flag)) else $error("idle step wrong");
  a_store_acc: assert property (ex && op == 4'h8 |->
    data_we && data_wdata == acc ##1 $stable(zero_flag) && $stable(acc)) else $error("store wrong");
endmodule
bind mce_exec mce_exec_props #(.PC_W(PC_W), .DADDR_W(DADDR_W)) i_mce_exec_props (.*);

// >>> tb/mce_mem_model.sv
// Program and data memory facing the core.
// Assumes combinational reads and a write on the clock edge.
module mce_mem_model (
  input wire clk,
  input wire [11:0] prog_addr,
  output logic [15:0] prog_data,
  input wire [7:0] data_addr,
  output logic [7:0] data_rdata,
  input wire [7:0] data_wdata,
  input wire data_we
);
  logic [15:0] rom [0:4095];
  logic [7:0] ram [0:255];
  // Combinational reads
  assign prog_data = rom[prog_addr];
  assign data_rdata = ram[data_addr];
  // Data write on the strobe
  always @(posedge clk) if (data_we) ram[data_addr] <= data_wdata;
endmodule

// >>> tb/mcu_core_instr_subset_exec_tb_top.sv
// Self-checking bench for the execution core.
// Assumes the memory model and the bound checker.
module mcu_core_instr_subset_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, wake = 0, watchdog_timeout_set = 0;
  wire [11:0] prog_addr;
  wire [15:0] prog_data;
  wire [7:0] data_addr, data_rdata, data_wdata, acc, watchdog_count, watchdog_prescale;
  wire data_we, zero_flag, power_down_flag, watchdog_timeout_flag, sys_clk_en;
  int failures = 0, samples_checked = 0;
  logic [15:0] prg [15] = '{16'h70ff, 16'h8010, 16'h4010, 16'h3010, 16'h1010, 16'h705a, 16'h8011,
    16'h6010, 16'h500b, 16'h7033, 16'h7033, 16'h0000, 16'h2000, 16'h7077, 16'h2000};
  mce_exec i_mce_exec (.*);
  mce_mem_model i_mce_mem_model (.*);
  // Free-running clock
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////
  // Compares and counts
  task chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) failures++;
    if (s !== e) $display("mismatch %s exp %h seen %h", n, e, s);
  endtask
  // Ends the run
  task wrap_up;
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Arithmetic and moves
  task t_data;
    step(3);
    chk("acc_z", {acc, zero_flag}, {8'h00, 1'b1});
    step(2);
    chk("acc_z", {acc, zero_flag}, {8'hff, 1'b0});
    step(3);
    chk("acc_z", {acc, zero_flag}, {8'h00, 1'b0});
    chk("ram10", i_mce_mem_model.ram[16], 8'h00);
    chk("ram11", i_mce_mem_model.ram[17], 8'h5a);
  endtask
  // Jump then power-down
  task t_jump_halt;
    step(2);
    chk("pc_acc", {prog_addr, acc}, {12'h00b, 8'h00});
    watchdog_timeout_set = 1;
    step(1);
    watchdog_timeout_set = 0;
    chk("pc_to", {prog_addr, watchdog_timeout_flag}, {12'h00c, 1'b1});
    step(5);
    chk("pc", prog_addr, 12'h00c);
    chk("pd_tmo_en", {power_down_flag, watchdog_timeout_flag, sys_clk_en}, 3'h4);
    chk("dog", {watchdog_count, watchdog_prescale}, 16'h0000);
  endtask
  // Wake from power-down, then a reset in mid-run
  task t_wake_reset;
    chk("acc_ram", {acc, i_mce_mem_model.ram[17]}, {8'h00, 8'h5a});
    wake = 1;
    step(1);
    wake = 0;
    step(1);
    chk("pc_acc_en", {prog_addr, acc, sys_clk_en}, {12'h00e, 8'h77, 1'b1});
    sys_rst = 1;
    step(2);
    chk("rst", {prog_addr, acc, zero_flag, power_down_flag, watchdog_timeout_flag, sys_clk_en},
      {12'h000, 8'h00, 4'h1});
    sys_rst = 0;
    step(3);
    chk("acc_z", {acc, zero_flag}, {8'h00, 1'b1});
  endtask
  initial begin
    foreach (prg[i]) i_mce_mem_model.rom[i] = prg[i];
    step(5);
    sys_rst = 0;
    t_data;
    t_jump_halt;
    t_wake_reset;
    wrap_up;
  end
  // Watchdog
  initial begin
    #2000 failures++;
    wrap_up;
  end
endmodule
